/* File: src/dpram_host_pkg.sv */
/*
 * constants, types and register map of the dual-port ram port controller.
 * assumes one 250 mhz clock and the ram port pins taken synchronously.
 */
package dpram_host_pkg;

    // -------------------------------------------------------------
    // register map
    // -------------------------------------------------------------
    localparam logic [3:0] REG_CMD    = 4'h0;
    localparam logic [3:0] REG_ADDR   = 4'h4;
    localparam logic [3:0] REG_WDATA  = 4'h8;
    localparam logic [3:0] REG_STATUS = 4'hc;
    localparam int ST_ACTIVE  = 0;
    localparam int ST_DONE    = 1;
    localparam int ST_MAILBOX = 2;
    localparam int ST_BUSY    = 3;
    localparam logic [11:0] ADDR_RESET  = 12'h000;
    localparam logic [7:0]  WDATA_RESET = 8'h00;
    localparam logic [2:0]  LAST_TOKEN  = 3'h7;

    typedef enum logic [2:0] {
        OP_MEM_RD   = 3'h0,
        OP_MEM_WR   = 3'h1,
        OP_SEM_RD   = 3'h2,
        OP_SEM_WR   = 3'h3,
        OP_SEM_INIT = 3'h4
    } op_t;

    typedef struct packed {
        logic [11:0] addr;
        logic [7:0]  data;
        logic        data_oe;
        logic        ce_n;
        logic        rw_n;
        logic        oe_n;
        logic        sem_n;
    } port_out_t;

    localparam port_out_t PINS_IDLE = '{12'h000, 8'h00, 1'b0,
                                        1'b1, 1'b1, 1'b1, 1'b1};

    // -------------------------------------------------------------
    // timing
    // -------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 4;

    function automatic int ns_to_cyc(input int ns);
        return (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    endfunction : ns_to_cyc

    localparam int BUSY_SETTLE_NS           = 20;
    localparam int WRITE_PULSE_NS           = 20;
    localparam int ACCESS_NS                = 25;
    localparam int CROSS_PORT_DATA_DELAY_NS = 30;
    localparam int ADDR_HOLD_NS             = 2;
    localparam int TOKEN_UPDATE_PULSE_NS    = 10;
    localparam int BUSY_SETTLE_CYC  = ns_to_cyc(BUSY_SETTLE_NS);
    localparam int WRITE_PULSE_CYC  = ns_to_cyc(WRITE_PULSE_NS);
    localparam int ACCESS_CYC       = ns_to_cyc(ACCESS_NS);
    localparam int CROSS_PORT_CYC   = ns_to_cyc(CROSS_PORT_DATA_DELAY_NS);
    localparam int READ_WAIT_CYC    = (ACCESS_CYC > CROSS_PORT_CYC) ?
                                      ACCESS_CYC : CROSS_PORT_CYC;
    localparam int ADDR_HOLD_CYC    = ns_to_cyc(ADDR_HOLD_NS);
    localparam int TOKEN_UPDATE_CYC = ns_to_cyc(TOKEN_UPDATE_PULSE_NS);
    localparam int TOKEN_SETTLE_CYC = 1;

endpackage : dpram_host_pkg

/* File: src/dpram_port_host.sv */
/*
 * controller for one port of the dual-port ram: takes commands over
 * avalon-mm and runs ram or token cycles on the port pins.
 * assumes pin inputs synchronous to clk and one master on the bus.
 */
`timescale 1ns/1ps
module dpram_port_host (
    input  wire logic                      clk,
    input  wire logic                      reset,
    input  wire logic [3:0]                avs_address,
    input  wire logic                      avs_read,
    input  wire logic                      avs_write,
    input  wire logic [31:0]               avs_writedata,
    output logic      [31:0]               avs_readdata,
    output logic                           avs_waitrequest,
    output dpram_host_pkg::port_out_t      port_out,
    input  wire logic [7:0]                data_in,
    input  wire logic                      busy_n_in,
    input  wire logic                      int_n_in
);

    typedef enum {S_IDLE, S_SETUP, S_ENABLE, S_STROBE, S_RELEASE} state_t;

    state_t                  state;
    logic [3:0]              cnt;
    dpram_host_pkg::op_t     op;
    logic [2:0]              idx;
    logic [11:0]             addr_reg;
    logic [7:0]              wdata_reg;
    logic [7:0]              rdata;
    logic                    done;
    logic                    bus_wr;
    logic                    start;
    logic                    finish;

    function automatic logic is_sem(input dpram_host_pkg::op_t o);
        return o == dpram_host_pkg::OP_SEM_RD ||
               o == dpram_host_pkg::OP_SEM_WR ||
               o == dpram_host_pkg::OP_SEM_INIT;
    endfunction : is_sem

    function automatic logic is_wr(input dpram_host_pkg::op_t o);
        return o == dpram_host_pkg::OP_MEM_WR ||
               o == dpram_host_pkg::OP_SEM_WR ||
               o == dpram_host_pkg::OP_SEM_INIT;
    endfunction : is_wr

    assign bus_wr = avs_write && !avs_waitrequest;
    assign start  = bus_wr && avs_address == dpram_host_pkg::REG_CMD &&
                    state == S_IDLE &&
                    avs_writedata[2:0] <= dpram_host_pkg::OP_SEM_INIT;
    assign finish = state == S_RELEASE && cnt <= 4'h1 &&
                    !(op == dpram_host_pkg::OP_SEM_INIT &&
                      idx != dpram_host_pkg::LAST_TOKEN);

    // -------------------------------------------------------------
    // avalon slave
    // -------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
        end else if ((avs_read || avs_write) && avs_waitrequest) begin
            avs_waitrequest <= 1'b0;
            avs_readdata    <= 32'h0000_0000;
            if (avs_read) begin
                unique case (avs_address)
                    dpram_host_pkg::REG_CMD:
                        avs_readdata <= {29'h0000_0000, op};
                    dpram_host_pkg::REG_ADDR:
                        avs_readdata <= {20'h0_0000, addr_reg};
                    dpram_host_pkg::REG_WDATA:
                        avs_readdata <= {24'h00_0000, wdata_reg};
                    dpram_host_pkg::REG_STATUS:
                        avs_readdata <= {16'h0000, rdata, 4'h0, !busy_n_in,
                                         !int_n_in, done, state != S_IDLE};
                    default:
                        avs_readdata <= 32'h0000_0000;
                endcase
            end
        end else begin
            avs_waitrequest <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            addr_reg  <= dpram_host_pkg::ADDR_RESET;
            wdata_reg <= dpram_host_pkg::WDATA_RESET;
        end else if (bus_wr) begin
            if (avs_address == dpram_host_pkg::REG_ADDR)
                addr_reg <= avs_writedata[11:0];
            if (avs_address == dpram_host_pkg::REG_WDATA)
                wdata_reg <= avs_writedata[7:0];
        end
    end

    // sticky done: completion wins over a clear in the same cycle
    always_ff @(posedge clk) begin
        if (reset)
            done <= 1'b0;
        else if (finish)
            done <= 1'b1;
        else if (bus_wr && avs_address == dpram_host_pkg::REG_STATUS &&
                 avs_writedata[dpram_host_pkg::ST_DONE])
            done <= 1'b0;
    end

    // -------------------------------------------------------------
    // port sequencer
    // -------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            state    <= S_IDLE;
            cnt      <= 4'h0;
            op       <= dpram_host_pkg::OP_MEM_RD;
            idx      <= 3'h0;
            rdata    <= 8'h00;
            port_out <= dpram_host_pkg::PINS_IDLE;
        end else begin
            unique case (state)
                S_IDLE: begin
                    port_out.data_oe <= 1'b0;
                    if (start) begin
                        op    <= dpram_host_pkg::op_t'(avs_writedata[2:0]);
                        idx   <= 3'h0;
                        state <= S_SETUP;
                        // address moves only with the write strobe high
                        if (avs_writedata[2:0] ==
                            dpram_host_pkg::OP_SEM_INIT) begin
                            port_out.addr <= 12'h000;
                            port_out.data <= 8'h01;
                        end else begin
                            port_out.addr <= addr_reg;
                            port_out.data <= wdata_reg;
                        end
                    end
                end
                S_SETUP: begin
                    port_out.ce_n  <= is_sem(op);
                    port_out.sem_n <= !is_sem(op);
                    port_out.oe_n  <= is_wr(op);
                    cnt   <= is_sem(op) ?
                             4'(dpram_host_pkg::TOKEN_SETTLE_CYC) :
                             4'(dpram_host_pkg::BUSY_SETTLE_CYC);
                    state <= S_ENABLE;
                end
                S_ENABLE: begin
                    if (cnt > 4'h1) begin
                        cnt <= cnt - 4'h1;
                    end else if (is_sem(op) || busy_n_in) begin
                        if (is_wr(op)) begin
                            port_out.rw_n    <= 1'b0;
                            port_out.data_oe <= 1'b1;
                            cnt <= 4'(dpram_host_pkg::WRITE_PULSE_CYC);
                        end else begin
                            cnt <= 4'(dpram_host_pkg::READ_WAIT_CYC);
                        end
                        state <= S_STROBE;
                    end
                end
                S_STROBE: begin
                    if (cnt > 4'h1) begin
                        cnt <= cnt - 4'h1;
                    end else begin
                        if (!is_wr(op))
                            rdata <= data_in;
                        port_out.rw_n  <= 1'b1;
                        port_out.oe_n  <= 1'b1;
                        port_out.ce_n  <= 1'b1;
                        port_out.sem_n <= 1'b1;
                        cnt   <= is_sem(op) ?
                                 4'(dpram_host_pkg::TOKEN_UPDATE_CYC) :
                                 4'(dpram_host_pkg::ADDR_HOLD_CYC);
                        state <= S_RELEASE;
                    end
                end
                S_RELEASE: begin
                    port_out.data_oe <= 1'b0;
                    if (cnt > 4'h1) begin
                        cnt <= cnt - 4'h1;
                    end else if (finish) begin
                        state <= S_IDLE;
                    end else begin
                        idx           <= idx + 3'h1;
                        port_out.addr <= {9'h000, idx + 3'h1};
                        state         <= S_SETUP;
                    end
                end
            endcase
        end
    end

    // -------------------------------------------------------------
    // checks
    // -------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    property p_write_enabled;
        !port_out.rw_n |-> !port_out.ce_n || !port_out.sem_n;
    endproperty
    a_write_enabled: assert property (p_write_enabled)
        else $error("write strobe low without an enable");

    property p_read_enabled;
        !port_out.oe_n |-> (port_out.ce_n != port_out.sem_n) &&
                           port_out.rw_n;
    endproperty
    a_read_enabled: assert property (p_read_enabled)
        else $error("output enable low without one enable");

    property p_addr_stable;
        !$stable(port_out.addr) |-> port_out.rw_n && $past(port_out.rw_n);
    endproperty
    a_addr_stable: assert property (p_addr_stable)
        else $error("address changed with write strobe low");

    property p_read_wait;
        $rose(port_out.oe_n) |-> $past(!port_out.oe_n, 8);
    endproperty
    a_read_wait: assert property (p_read_wait)
        else $error("read ended before cross-port delay");

    property p_busy_settled;
        $fell(port_out.rw_n) && !port_out.ce_n |->
            busy_n_in && !$past(port_out.ce_n, 5);
    endproperty
    a_busy_settled: assert property (p_busy_settled)
        else $error("write began before busy settled");

    property p_token_ce_high;
        !port_out.sem_n |-> port_out.ce_n;
    endproperty
    a_token_ce_high: assert property (p_token_ce_high)
        else $error("chip enable low during token access");

    property p_token_update;
        $rose(port_out.sem_n) && $rose(port_out.rw_n) |->
            port_out.sem_n [*3];
    endproperty
    a_token_update: assert property (p_token_update)
        else $error("token enable pulse too short after write");

    property p_init_all_free;
        (!port_out.rw_n && op == dpram_host_pkg::OP_SEM_INIT |->
            port_out.data[0] && port_out.data_oe) and
        (finish && op == dpram_host_pkg::OP_SEM_INIT |->
            port_out.addr == {9'h000, dpram_host_pkg::LAST_TOKEN});
    endproperty
    a_init_all_free: assert property (p_init_all_free)
        else $error("token init skipped a latch or wrote zero");

endmodule : dpram_port_host

/* File: tb/dpram_model.sv */
/* behavioural dual-port ram seen from the host port; the far port is
   worked by bench tasks. assumes the design package and one clock. */
`timescale 1ns/1ps
module dpram_model (
    input  wire logic                      clk,
    input  wire dpram_host_pkg::port_out_t p,
    output logic [7:0]                     bus,
    output logic                           busy_n,
    output logic                           int_n
);
    // ----------------------------------------------------------
    // array, tokens, flags
    // ----------------------------------------------------------
    logic [7:0]  mem [4096];
    logic [7:0]  req_l = 8'h00, own_l = 8'h00;
    logic [7:0]  req_r = 8'h5a, own_r = 8'h5a;
    logic [7:0]  wd, last = 8'h00;
    logic [11:0] wa, other_addr = 12'h000;
    logic        right_flag = 1'b0, other_on = 1'b0;
    logic        wr_q = 1'b0, rd_q = 1'b0, blocked = 1'b0;
    logic        sem_w, tok_hold;
    wire logic   wr = !p.rw_n && (!p.ce_n || !p.sem_n);
    wire logic   rd = p.rw_n && !p.oe_n && (!p.ce_n || !p.sem_n);
    wire logic [2:0] t = p.addr[2:0];
    initial int_n = 1'b1;
    assign busy_n = !(other_on && !p.ce_n && other_addr == p.addr);
    always_comb begin
        if (p.data_oe) bus = p.data;
        else if (rd && !p.ce_n) bus = mem[p.addr];
        else if (rd) bus = {8{rd_q ? tok_hold : !own_l[t]}};
        else bus = ~last;
    end
    task automatic tok(input logic left, input logic [2:0] i,
                       input logic v);
        if (left) req_l[i] = !v;
        else req_r[i] = !v;
        if (!req_l[i]) own_l[i] = 1'b0;
        if (!req_r[i]) own_r[i] = 1'b0;
        if (!own_l[i] && !own_r[i]) begin
            own_l[i] = req_l[i] && (left || !req_r[i]);
            own_r[i] = req_r[i] && !own_l[i];
        end
    endtask : tok
    task automatic other_wr(input logic [11:0] a, input logic [7:0] d);
        mem[a] = d;
        if (a == 12'hffe) int_n = 1'b0;
    endtask : other_wr
    task automatic other_rd(input logic [11:0] a, output logic [7:0] d);
        d = mem[a];
        if (a == 12'hfff) right_flag = 1'b0;
    endtask : other_rd
    always @(posedge clk) begin
        last <= bus;
        wr_q <= wr;
        rd_q <= rd && !p.sem_n;
        if (rd && !p.sem_n && !rd_q) tok_hold <= !own_l[t];
        if (rd && !p.ce_n && p.addr == 12'hffe) int_n <= 1'b1;
        if (wr) begin
            wa <= p.addr;
            wd <= bus;
            sem_w <= !p.sem_n;
            blocked <= blocked || !busy_n;
        end
        if (wr_q && !wr) begin
            blocked <= 1'b0;
            if (sem_w) tok(1'b1, wa[2:0], wd[0]);
            else if (!blocked) begin
                mem[wa] <= wd;
                if (wa == 12'hfff) right_flag <= 1'b1;
            end
        end
    end
endmodule : dpram_model

/* File: tb/test_dpram_port_host.sv */
/* self-checking bench for dpram_port_host with the ram model.
   assumes the package and tb/dpram_model.sv are compiled first. */
`timescale 1ns/1ps
module test_dpram_port_host;
    // ----------------------------------------------------------
    // bench
    // ----------------------------------------------------------
    logic        clk, reset, avs_read, avs_write, avs_waitrequest;
    logic [3:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, rv, st;
    logic [7:0]  data_in, d;
    logic [11:0] addr_q;
    logic        busy_n_in, int_n_in;
    dpram_host_pkg::port_out_t port_out;
    int          num_errors = 0;
    int          checked = 0;
    dpram_port_host dut (.clk(clk), .reset(reset),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .port_out(port_out), .data_in(data_in),
        .busy_n_in(busy_n_in), .int_n_in(int_n_in));
    dpram_model pm (.clk(clk), .p(port_out), .bus(data_in),
        .busy_n(busy_n_in), .int_n(int_n_in));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic tally_and_finish;
        if (num_errors == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : tally_and_finish
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [31:0] v);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= v;
        avs_write <= w;
        avs_read <= !w;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        rv = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus
    task automatic wait_done(input int lim);
        for (int i = 0; i < lim; i++) begin
            bus(1'b0, dpram_host_pkg::REG_STATUS, 32'h0);
            if (rv[dpram_host_pkg::ST_DONE] === 1'b1) break;
        end
        st = rv;
        if (st[dpram_host_pkg::ST_DONE] === 1'b1)
            bus(1'b1, dpram_host_pkg::REG_STATUS, 32'h2);
    endtask : wait_done
    task automatic op(input dpram_host_pkg::op_t c, input logic [11:0] a,
                      input logic [7:0] v, input int lim);
        bus(1'b1, dpram_host_pkg::REG_ADDR, {20'h0, a});
        bus(1'b1, dpram_host_pkg::REG_WDATA, {24'h0, v});
        bus(1'b1, dpram_host_pkg::REG_CMD, {29'h0, c});
        wait_done(lim);
    endtask : op
    always @(posedge clk) begin
        if (!reset && !port_out.sem_n && !port_out.ce_n) check(1'b0, 1'b1);
        if (!reset && !port_out.rw_n && port_out.addr !== addr_q) check(1'b0, 1'b1);
        if (port_out.data_oe && pm.rd) check(1'b0, 1'b1);
        addr_q <= port_out.addr;
    end
    task automatic t_reset;
        check(port_out, dpram_host_pkg::PINS_IDLE);
        bus(1'b0, dpram_host_pkg::REG_ADDR, 32'h0);
        check(rv, 32'h0);
        bus(1'b0, dpram_host_pkg::REG_STATUS, 32'h0);
        check(rv, 32'h0);
        bus(1'b1, 4'h2, 32'hffff);
        bus(1'b0, 4'h2, 32'h0);
        check(rv, 32'h0);
        bus(1'b1, dpram_host_pkg::REG_CMD, 32'h5);
        bus(1'b0, dpram_host_pkg::REG_STATUS, 32'h0);
        check(rv[dpram_host_pkg::ST_ACTIVE], 1'b0);
    endtask : t_reset
    task automatic t_mem;
        op(dpram_host_pkg::OP_MEM_WR, 12'hfff, 8'h3c, 40);
        check(pm.mem[12'hfff], 8'h3c);
        check(pm.right_flag, 1'b1);
        bus(1'b0, dpram_host_pkg::REG_CMD, 32'h0);
        check(rv, {29'h0, dpram_host_pkg::OP_MEM_WR});
        bus(1'b0, dpram_host_pkg::REG_ADDR, 32'h0);
        check(rv, 32'h0000_0fff);
        bus(1'b0, dpram_host_pkg::REG_WDATA, 32'h0);
        check(rv, 32'h0000_003c);
        pm.other_rd(12'hfff, d);
        check(pm.right_flag, 1'b0);
        pm.other_wr(12'hffe, 8'h96);
        bus(1'b0, dpram_host_pkg::REG_STATUS, 32'h0);
        check(rv[dpram_host_pkg::ST_MAILBOX], 1'b1);
        op(dpram_host_pkg::OP_MEM_RD, 12'hffe, 8'h00, 40);
        check(st[15:8], 8'h96);
        bus(1'b0, dpram_host_pkg::REG_STATUS, 32'h0);
        check(rv[dpram_host_pkg::ST_MAILBOX], 1'b0);
    endtask : t_mem
    task automatic t_token;
        op(dpram_host_pkg::OP_SEM_INIT, 12'h0, 8'h0, 80);
        for (int i = 0; i < 8; i++) pm.tok(1'b0, i[2:0], 1'b1);
        op(dpram_host_pkg::OP_SEM_RD, 12'h003, 8'h00, 40);
        check(st[15:8], 8'hff);
        op(dpram_host_pkg::OP_SEM_WR, 12'hff3, 8'hfe, 40);
        op(dpram_host_pkg::OP_SEM_RD, 12'h003, 8'h00, 40);
        check(st[15:8], 8'h00);
        pm.tok(1'b0, 3'h3, 1'b0);
        check(pm.own_r, 8'h00);
        op(dpram_host_pkg::OP_SEM_WR, 12'h003, 8'h01, 40);
        check(pm.own_r, 8'h08);
        op(dpram_host_pkg::OP_SEM_RD, 12'h003, 8'h00, 40);
        check(st[15:8], 8'hff);
    endtask : t_token
    task automatic t_busy;
        pm.other_wr(12'h055, 8'h11);
        pm.other_addr = 12'h055;
        pm.other_on = 1'b1;
        op(dpram_host_pkg::OP_MEM_WR, 12'h055, 8'h77, 10);
        check(st[dpram_host_pkg::ST_DONE], 1'b0);
        check(st[dpram_host_pkg::ST_ACTIVE], 1'b1);
        check(st[dpram_host_pkg::ST_BUSY], 1'b1);
        check(pm.mem[12'h055], 8'h11);
        pm.other_on = 1'b0;
        wait_done(40);
        check(pm.mem[12'h055], 8'h77);
    endtask : t_busy
    initial begin
        #100000;
        num_errors++;
        tally_and_finish;
    end
    initial begin
        reset = 1'b1;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 4'h0;
        avs_writedata = 32'h0;
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        t_reset;
        t_mem;
        t_token;
        t_busy;
        tally_and_finish;
    end
endmodule : test_dpram_port_host
